/* File: power_on_strap_decoder.sv */
// Power-on strap capture, decode and register slave
//
// What this block does
// - Configuration comes from pins 0-7, 12-15, 29 and 31
// - Pin 0: low host bus, high PCI
// - Pins 2:1 pick host bus variant
// - Pin 3: low PLL, high test clock
// - Pin 4 sets variant-A ready polarity
// - Pins 6:5 set memory column size
// - Pin 7 high resets clock divider
// - Pin 12 low drives chip selects
// - Pins 15:13 select local memory size
// - Variant B: pins 31,29 pick host clock
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module power_on_strap_decoder #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic [31:0]           gpio_i,
	input  wire logic [ADDR_WIDTH-1:0] address_i,
	input  wire logic                  read_i,
	input  wire logic                  write_i,
	input  wire logic [31:0]           writedata_i,
	input  wire logic [3:0]            byteenable_i,
	output logic      [31:0]           readdata_o,
	output logic                       waitrequest_o,
	output logic      [1:0]            response_o,
	output logic                       config_valid_o,
	output logic                       host_family_pci_o,
	output logic      [1:0]            host_variant_o,
	output logic                       core_clock_external_o,
	output logic                       ready_active_high_o,
	output logic      [10:0]           column_words_o,
	output logic                       clock_divider_reset_o,
	output logic                       memory_chip_select_n_drive_o,
	output logic      [6:0]            memory_size_mb_o,
	output logic      [1:0]            host_clock_source_o,
	output logic                       config_error_o
);

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_type;

	bus_state_type state_r;
	bus_state_type state_nxt;

	logic [31:0] captured_r;
	logic [31:0] override_value_r;
	logic        override_enable_r;
	logic [31:0] effective;
	logic [31:0] decoded_word;
	logic [31:0] status_word;
	logic [31:0] read_mux;
	logic        addr_hit;
	logic        write_take;
	logic        variant_undef;
	logic        memsize_undef;
	logic [1:0]  variant_code;
	logic [1:0]  hclk_code;
	logic        sel_raw;
	logic        sel_decoded;
	logic        sel_value;
	logic        sel_enable;
	logic        sel_status;

	localparam int LANES     = 4;
	localparam int LANE_BITS = 8;
	localparam logic [31:0] OVERRIDE_RESET =
		power_on_strap_pkg::OVERRIDE_VALUE_RESET;

	function automatic logic [10:0] column_words(input logic [1:0] code);
		// Top bit low covers both 00 and 01
		if (!code[1])
			column_words = power_on_strap_pkg::COLUMN_WORDS_256;
		else if (!code[0])
			column_words = power_on_strap_pkg::COLUMN_WORDS_512;
		else
			column_words = power_on_strap_pkg::COLUMN_WORDS_1024;
	endfunction : column_words

	function automatic logic [6:0] memory_mb(input logic [2:0] code);
		case (code)
			3'h0:    memory_mb = power_on_strap_pkg::MEM_MB_4;
			3'h1:    memory_mb = power_on_strap_pkg::MEM_MB_8;
			3'h2:    memory_mb = power_on_strap_pkg::MEM_MB_16;
			3'h3:    memory_mb = power_on_strap_pkg::MEM_MB_32;
			3'h4:    memory_mb = power_on_strap_pkg::MEM_MB_64;
			3'h5:    memory_mb = power_on_strap_pkg::MEM_MB_2;
			default: memory_mb = power_on_strap_pkg::MEM_MB_UNDEF;
		endcase
	endfunction : memory_mb

	function automatic logic [1:0] host_clock(
		input logic [1:0] variant,
		input logic       hi,
		input logic       lo
	);
		if (variant != power_on_strap_pkg::VARIANT_B)
			host_clock = power_on_strap_pkg::HCLK_FROM_PLL;
		else if (hi)
			host_clock = power_on_strap_pkg::HCLK_FROM_GPIO30;
		else if (lo)
			host_clock = power_on_strap_pkg::HCLK_FROM_PIN;
		else
			host_clock = power_on_strap_pkg::HCLK_FROM_PLL;
	endfunction : host_clock

	// Offsets are bytes; the cast keeps the compare at bus width
	function automatic logic addr_is(
		input logic [ADDR_WIDTH-1:0] addr,
		input logic [7:0]            offset
	);
		addr_is = (addr == ADDR_WIDTH'(offset));
	endfunction : addr_is

	// capture during reset
	// Pins are free for other uses afterwards, so the copy freezes
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			captured_r <= gpio_i & power_on_strap_pkg::STRAP_PIN_MASK;
	end

	// Software override sits in front of the decoder
	always_comb
	begin
		if (override_enable_r)
			effective = override_value_r & power_on_strap_pkg::STRAP_PIN_MASK;
		else
			effective = captured_r;
	end

	assign variant_code = effective[power_on_strap_pkg::PIN_VARIANT_HI:
		power_on_strap_pkg::PIN_VARIANT_LO];
	assign variant_undef = (variant_code == power_on_strap_pkg::VARIANT_UNDEF);
	assign memsize_undef = memory_mb(
		effective[power_on_strap_pkg::PIN_MEMSIZE_HI:
		power_on_strap_pkg::PIN_MEMSIZE_LO]) ==
		power_on_strap_pkg::MEM_MB_UNDEF;
	// host clock for variant B only
	assign hclk_code = host_clock(variant_code,
		effective[power_on_strap_pkg::PIN_HCLK_HI],
		effective[power_on_strap_pkg::PIN_HCLK_LO]);

	// Select lines shared by the read and write paths
	assign sel_raw = addr_is(address_i,
		power_on_strap_pkg::REG_STRAP_RAW);
	assign sel_decoded = addr_is(address_i,
		power_on_strap_pkg::REG_DECODED);
	assign sel_value = addr_is(address_i,
		power_on_strap_pkg::REG_OVERRIDE_VALUE);
	assign sel_enable = addr_is(address_i,
		power_on_strap_pkg::REG_OVERRIDE_ENABLE);
	assign sel_status = addr_is(address_i,
		power_on_strap_pkg::REG_STATUS);

	always_comb
	begin
		decoded_word = 32'h0000_0000;
		decoded_word[power_on_strap_pkg::DEC_PCI] =
			effective[power_on_strap_pkg::PIN_BUS_FAMILY];
		decoded_word[power_on_strap_pkg::DEC_VARIANT_LO +: 2] = variant_code;
		decoded_word[power_on_strap_pkg::DEC_EXT_CLOCK] =
			effective[power_on_strap_pkg::PIN_CLOCK_SOURCE];
		decoded_word[power_on_strap_pkg::DEC_READY_HIGH] =
			effective[power_on_strap_pkg::PIN_READY_POL];
		decoded_word[power_on_strap_pkg::DEC_DIV_RESET] =
			effective[power_on_strap_pkg::PIN_DIVIDER_RESET];
		decoded_word[power_on_strap_pkg::DEC_CS_DRIVE] =
			!effective[power_on_strap_pkg::PIN_CHIP_SELECT];
		decoded_word[power_on_strap_pkg::DEC_HCLK_LO +: 2] = hclk_code;
		decoded_word[power_on_strap_pkg::DEC_MEMSIZE_LO +: 7] = memory_mb(
			effective[power_on_strap_pkg::PIN_MEMSIZE_HI:
			power_on_strap_pkg::PIN_MEMSIZE_LO]);
		decoded_word[power_on_strap_pkg::DEC_COLUMN_LO +: 11] = column_words(
			effective[power_on_strap_pkg::PIN_COLUMN_HI:
			power_on_strap_pkg::PIN_COLUMN_LO]);
	end

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[power_on_strap_pkg::STAT_VARIANT_UNDEF] = variant_undef;
		status_word[power_on_strap_pkg::STAT_MEMSIZE_UNDEF] = memsize_undef;
		status_word[power_on_strap_pkg::STAT_OVERRIDE_ON] = override_enable_r;
	end

	// configuration outputs
	// Reset shows the all-pulled-down decode; valid marks the real one
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			config_valid_o               <= 1'b0;
			host_family_pci_o            <= 1'b0;
			host_variant_o               <= power_on_strap_pkg::VARIANT_A;
			core_clock_external_o        <= 1'b0;
			ready_active_high_o          <= 1'b0;
			column_words_o               <= power_on_strap_pkg::COLUMN_WORDS_256;
			clock_divider_reset_o        <= 1'b0;
			memory_chip_select_n_drive_o <= 1'b1;
			memory_size_mb_o             <= power_on_strap_pkg::MEM_MB_4;
			host_clock_source_o          <= power_on_strap_pkg::HCLK_FROM_PLL;
			config_error_o               <= 1'b0;
		end
		else
		begin
			config_valid_o <= 1'b1;
			host_family_pci_o <= decoded_word[power_on_strap_pkg::DEC_PCI];
			host_variant_o <= variant_code;
			core_clock_external_o <=
				decoded_word[power_on_strap_pkg::DEC_EXT_CLOCK];
			ready_active_high_o <=
				decoded_word[power_on_strap_pkg::DEC_READY_HIGH];
			column_words_o <=
				decoded_word[power_on_strap_pkg::DEC_COLUMN_LO +: 11];
			clock_divider_reset_o <=
				decoded_word[power_on_strap_pkg::DEC_DIV_RESET];
			memory_chip_select_n_drive_o <=
				decoded_word[power_on_strap_pkg::DEC_CS_DRIVE];
			memory_size_mb_o <=
				decoded_word[power_on_strap_pkg::DEC_MEMSIZE_LO +: 7];
			host_clock_source_o <= hclk_code;
			config_error_o <= variant_undef || memsize_undef;
		end
	end

	// Address decode
	always_comb
	begin
		addr_hit = 1'b1;
		if (sel_raw)
			read_mux = captured_r;
		else if (sel_decoded)
			read_mux = decoded_word;
		else if (sel_value)
			read_mux = override_value_r;
		else if (sel_enable)
			read_mux = {31'h0000_0000, override_enable_r};
		else if (sel_status)
			read_mux = status_word;
		else
		begin
			read_mux = 32'h0000_0000;
			addr_hit = 1'b0;
		end
	end

	// One wait cycle per access; the write lands at the end of the cycle with waitrequest low
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			BUS_IDLE:
				if (read_i || write_i)
					state_nxt = BUS_ACK;
			BUS_ACK:
				state_nxt = BUS_IDLE;
			default:
				state_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			state_r <= BUS_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			waitrequest_o <= 1'b1;
		else
			waitrequest_o <= !(state_nxt == BUS_ACK);
	end

	// Read data stands only in the acknowledge cycle
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			readdata_o <= 32'h0000_0000;
			response_o <= power_on_strap_pkg::RESP_OKAY;
		end
		else if (state_r == BUS_IDLE && (read_i || write_i))
		begin
			readdata_o <= read_i ? read_mux : 32'h0000_0000;
			response_o <= addr_hit ? power_on_strap_pkg::RESP_OKAY
				: power_on_strap_pkg::RESP_SLVERR;
		end
		else
		begin
			readdata_o <= 32'h0000_0000;
			response_o <= power_on_strap_pkg::RESP_OKAY;
		end
	end

	assign write_take = write_i && (state_r == BUS_ACK);

	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++)
		begin : g_override_lane
			localparam int BASE = lane * LANE_BITS;
			always_ff @(posedge clock_i)
			begin
				if (rst_i)
					override_value_r[BASE +: LANE_BITS] <=
						OVERRIDE_RESET[BASE +: LANE_BITS];
				else if (write_take && byteenable_i[lane] &&
					sel_value)
					override_value_r[BASE +: LANE_BITS] <=
						writedata_i[BASE +: LANE_BITS];
			end
		end
	endgenerate

	// Override is off after reset so the straps rule first
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			override_enable_r <= 1'b0;
		else if (write_take && byteenable_i[0] && sel_enable)
			override_enable_r <= writedata_i[0];
	end

endmodule : power_on_strap_decoder

`default_nettype wire

/* File: power_on_strap_decoder_tb.sv */
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module power_on_strap_decoder_tb;
	logic        clock_i = 0;
	logic        rst_i = 1;
	logic [31:0] pull_up = 0;
	logic        drive_en = 0;
	logic [31:0] drive = 0;
	logic [31:0] gpio;
	logic [7:0]  address_i = 0;
	logic        read_i = 0;
	logic        write_i = 0;
	logic [31:0] writedata_i = 0;
	logic [3:0]  byteenable_i = 4'hF;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic [1:0]  response_o;
	logic        config_valid_o;
	logic [1:0]  host_variant_o;
	logic [33:0] q[$];
	logic [31:0] seed = 32'h7044;
	logic [31:0] s;
	logic [31:0] w;
	int          n_fail = 0;
	int          compares = 0;
	int          cyc = 0;
	initial forever #2.5 clock_i = ~clock_i;
	strap_board board (.pull_up_i(pull_up), .drive_en_i(drive_en),
		.drive_i(drive), .gpio_o(gpio));
	power_on_strap_decoder dut (.clock_i(clock_i), .rst_i(rst_i),
		.gpio_i(gpio), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .response_o(response_o),
		.config_valid_o(config_valid_o), .host_family_pci_o(),
		.host_variant_o(host_variant_o), .core_clock_external_o(),
		.ready_active_high_o(), .column_words_o(),
		.clock_divider_reset_o(), .memory_chip_select_n_drive_o(),
		.memory_size_mb_o(), .host_clock_source_o(), .config_error_o());
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic [31:0] dec(input logic [31:0] v);
		logic [31:0] d;
		logic [2:0]  m;
		d = 32'h0;
		m = v[15:13];
		d[5:0] = {v[7], v[4:0]};
		d[6] = !v[12];
		d[8:7] = v[2:1] != 2'b01 ? 2'h0 : (v[31] ? 2'h2 : {1'b0, v[29]});
		d[15:9] = m < 5 ? 7'h04 << m : (m == 5 ? 7'h02 : 7'h00);
		d[26:16] = v[6] ? (v[5] ? 11'h400 : 11'h200) : 11'h100;
		return d;
	endfunction : dec
	task chk(input string n, input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task print_verdict();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// Hold the request until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		q.push_back(e);
		address_i <= a;
		writedata_i <= d;
		read_i <= !w;
		write_i <= w;
		@(posedge clock_i);
		while (waitrequest_o)
			@(posedge clock_i);
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask : bus
	task boot(input logic [31:0] v);
		pull_up <= v;
		drive_en <= 1'b0;
		rst_i <= 1'b1;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask : boot
	always @(posedge clock_i)
	begin
		if (!rst_i && waitrequest_o !== 1'b1)
		begin
			if (q.size() == 0)
				chk("unexpected answer", 34'h0, 34'h1);
			else
				chk("bus answer", q.pop_front(),
					{response_o, readdata_o});
		end
	end
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		boot(32'h0);
		bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(0)});
		$display("test default done");
		for (int i = 0; i < 32; i++)
		begin
			s = xs();
			s[15:13] = i[2:0];
			s[2:1] = i[4:3];
			boot(s);
			bus(0, power_on_strap_pkg::REG_STRAP_RAW, 0,
				{2'h0, s & power_on_strap_pkg::STRAP_PIN_MASK});
			bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(s)});
			drive <= xs();
			drive_en <= 1'b1;
			bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(s)});
			chk("variant", {32'h0, s[2:1]}, {32'h0, host_variant_o});
			chk("valid", 34'h1, {33'h0, config_valid_o});
			bus(0, power_on_strap_pkg::REG_STATUS, 0,
				{31'h0, 1'b0, s[15] & s[14], s[2:1] == 2'b10});
			$display("test strap %0d done", i);
		end
		// Read-only and unmapped places
		bus(1, power_on_strap_pkg::REG_DECODED, 32'hFFFFFFFF, 34'h0);
		bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(s)});
		bus(0, 8'h14, 0, {power_on_strap_pkg::RESP_SLVERR, 32'h0});
		bus(1, 8'h14, 32'h1, {power_on_strap_pkg::RESP_SLVERR, 32'h0});
		$display("test bus done");
		// Override replaces the straps; lane enables split the word
		w = xs();
		bus(1, power_on_strap_pkg::REG_OVERRIDE_VALUE, ~w, 34'h0);
		byteenable_i <= 4'hE;
		bus(1, power_on_strap_pkg::REG_OVERRIDE_VALUE, w, 34'h0);
		byteenable_i <= 4'hF;
		bus(0, power_on_strap_pkg::REG_OVERRIDE_VALUE, 0,
			{2'h0, w[31:8], ~w[7:0]});
		w[7:0] = ~w[7:0];
		bus(1, power_on_strap_pkg::REG_OVERRIDE_ENABLE, 32'h1, 34'h0);
		bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(w)});
		bus(0, power_on_strap_pkg::REG_STATUS, 0,
			{31'h0, 1'b1, w[15] & w[14], w[2:1] == 2'b10});
		bus(0, power_on_strap_pkg::REG_STRAP_RAW, 0,
			{2'h0, s & power_on_strap_pkg::STRAP_PIN_MASK});
		chk("override variant", {32'h0, w[2:1]},
			{32'h0, host_variant_o});
		bus(1, power_on_strap_pkg::REG_OVERRIDE_ENABLE, 32'h0, 34'h0);
		bus(0, power_on_strap_pkg::REG_DECODED, 0, {2'h0, dec(s)});
		chk("variant", {32'h0, s[2:1]}, {32'h0, host_variant_o});
		$display("test override done");
		print_verdict();
	end
endmodule : power_on_strap_decoder_tb
bind power_on_strap_decoder strap_props props (.clock_i(clock_i),
	.rst_i(rst_i), .gpio_i(gpio_i), .read_i(read_i), .write_i(write_i),
	.waitrequest_o(waitrequest_o), .config_valid_o(config_valid_o),
	.host_family_pci_o(host_family_pci_o),
	.host_variant_o(host_variant_o), .column_words_o(column_words_o),
	.memory_chip_select_n_drive_o(memory_chip_select_n_drive_o),
	.memory_size_mb_o(memory_size_mb_o),
	.host_clock_source_o(host_clock_source_o),
	.core_clock_external_o(core_clock_external_o),
	.ready_active_high_o(ready_active_high_o),
	.clock_divider_reset_o(clock_divider_reset_o),
	.config_error_o(config_error_o));
`default_nettype wire

/* File: power_on_strap_pkg.sv */
// Constants shared by the power-on strap decoder
package power_on_strap_pkg;

	// Strap pin positions on the general-purpose pin bus
	localparam int PIN_BUS_FAMILY    = 0;
	localparam int PIN_VARIANT_LO    = 1;
	localparam int PIN_VARIANT_HI    = 2;
	localparam int PIN_CLOCK_SOURCE  = 3;
	localparam int PIN_READY_POL     = 4;
	localparam int PIN_COLUMN_LO     = 5;
	localparam int PIN_COLUMN_HI     = 6;
	localparam int PIN_DIVIDER_RESET = 7;
	localparam int PIN_CHIP_SELECT   = 12;
	localparam int PIN_MEMSIZE_LO    = 13;
	localparam int PIN_MEMSIZE_HI    = 15;
	localparam int PIN_HCLK_LO       = 29;
	localparam int PIN_HCLK_HI       = 31;

	// Pins 0-7, 12-15, 29 and 31 carry straps
	localparam logic [31:0] STRAP_PIN_MASK = 32'hA000_F0FF;

	typedef enum logic [1:0] {
		VARIANT_A     = 2'b00,
		VARIANT_B     = 2'b01,
		VARIANT_UNDEF = 2'b10,
		VARIANT_C     = 2'b11
	} host_variant_type;

	localparam logic [1:0] HCLK_FROM_PLL    = 2'h0;
	localparam logic [1:0] HCLK_FROM_PIN    = 2'h1;
	localparam logic [1:0] HCLK_FROM_GPIO30 = 2'h2;

	localparam logic [10:0] COLUMN_WORDS_256  = 11'h100;
	localparam logic [10:0] COLUMN_WORDS_512  = 11'h200;
	localparam logic [10:0] COLUMN_WORDS_1024 = 11'h400;

	localparam logic [6:0] MEM_MB_2     = 7'h02;
	localparam logic [6:0] MEM_MB_4     = 7'h04;
	localparam logic [6:0] MEM_MB_8     = 7'h08;
	localparam logic [6:0] MEM_MB_16    = 7'h10;
	localparam logic [6:0] MEM_MB_32    = 7'h20;
	localparam logic [6:0] MEM_MB_64    = 7'h40;
	localparam logic [6:0] MEM_MB_UNDEF = 7'h00;

	// Register byte offsets
	localparam logic [7:0] REG_STRAP_RAW       = 8'h00;
	localparam logic [7:0] REG_DECODED         = 8'h04;
	localparam logic [7:0] REG_OVERRIDE_VALUE  = 8'h08;
	localparam logic [7:0] REG_OVERRIDE_ENABLE = 8'h0C;
	localparam logic [7:0] REG_STATUS          = 8'h10;

	// Decoded register field positions
	localparam int DEC_PCI        = 0;
	localparam int DEC_VARIANT_LO = 1;
	localparam int DEC_EXT_CLOCK  = 3;
	localparam int DEC_READY_HIGH = 4;
	localparam int DEC_DIV_RESET  = 5;
	localparam int DEC_CS_DRIVE   = 6;
	localparam int DEC_HCLK_LO    = 7;
	localparam int DEC_MEMSIZE_LO = 9;
	localparam int DEC_COLUMN_LO  = 16;

	// Status register field positions
	localparam int STAT_VARIANT_UNDEF = 0;
	localparam int STAT_MEMSIZE_UNDEF = 1;
	localparam int STAT_OVERRIDE_ON   = 2;

	localparam logic [31:0] OVERRIDE_VALUE_RESET = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY            = 2'h0;
	localparam logic [1:0]  RESP_SLVERR          = 2'h2;

endpackage : power_on_strap_pkg

/* File: strap_board.sv */
// Board strap resistors and later pin traffic
`timescale 1ns/1ps
`default_nettype none
module strap_board (
	input wire logic [31:0] pull_up_i,
	input wire logic        drive_en_i,
	input wire logic [31:0] drive_i,
	output logic     [31:0] gpio_o
);
	// pulled low unless fitted, reused later
	assign gpio_o = drive_en_i ? drive_i : pull_up_i;
endmodule : strap_board
`default_nettype wire

/* File: strap_props.sv */
// Assertions on the strap decoder ports
`timescale 1ns/1ps
`default_nettype none
module strap_props (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic [31:0] gpio_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic        waitrequest_o,
	input wire logic        config_valid_o,
	input wire logic        host_family_pci_o,
	input wire logic [1:0]  host_variant_o,
	input wire logic [10:0] column_words_o,
	input wire logic        memory_chip_select_n_drive_o,
	input wire logic [6:0]  memory_size_mb_o,
	input wire logic [1:0]  host_clock_source_o,
	input wire logic        core_clock_external_o,
	input wire logic        ready_active_high_o,
	input wire logic        clock_divider_reset_o,
	input wire logic        config_error_o
);
	logic [31:0] cap_r;
	logic        wr_r;
	logic        ok;
	logic [2:0]  m;
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			cap_r <= gpio_i;
	end
	// Any write may turn the override on
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			wr_r <= 1'b0;
		else if (write_i && !waitrequest_o)
			wr_r <= 1'b1;
	end
	assign ok = config_valid_o && !wr_r;
	assign m = cap_r[15:13];
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	property p_family; ok |-> host_family_pci_o == cap_r[0]; endproperty
	a_family: assert property (p_family) else $error("family bad");
	property p_variant; ok |-> host_variant_o == cap_r[2:1]; endproperty
	a_variant: assert property (p_variant) else $error("variant bad");
	property p_column;
		ok |-> column_words_o == (cap_r[6] ?
			(cap_r[5] ? 11'h400 : 11'h200) : 11'h100);
	endproperty
	a_column: assert property (p_column) else $error("column bad");
	property p_cs; ok |-> memory_chip_select_n_drive_o == !cap_r[12];
	endproperty
	a_cs: assert property (p_cs) else $error("chip select bad");
	property p_mem;
		ok |-> memory_size_mb_o == (m < 5 ? 7'h04 << m :
			(m == 5 ? 7'h02 : 7'h00));
	endproperty
	a_mem: assert property (p_mem) else $error("mem size bad");
	property p_hclk;
		ok |-> host_clock_source_o == (cap_r[2:1] != 2'b01 ? 2'h0 :
			(cap_r[31] ? 2'h2 : {1'b0, cap_r[29]}));
	endproperty
	a_hclk: assert property (p_hclk) else $error("host clock bad");
	property p_hold;
		ok && $past(ok) |-> $stable(memory_size_mb_o)
			&& $stable(host_variant_o);
	endproperty
	a_hold: assert property (p_hold) else $error("config moved");
	property p_ack;
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1
			waitrequest_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer bad");
	property p_ext; ok |-> core_clock_external_o == cap_r[3]; endproperty
	a_ext: assert property (p_ext) else $error("clock source bad");
	property p_ready; ok |-> ready_active_high_o == cap_r[4]; endproperty
	a_ready: assert property (p_ready) else $error("ready bad");
	property p_div; ok |-> clock_divider_reset_o == cap_r[7]; endproperty
	a_div: assert property (p_div) else $error("divider bad");
	property p_err;
		ok |-> config_error_o == (cap_r[2:1] == 2'b10 || m > 5);
	endproperty
	a_err: assert property (p_err) else $error("error flag bad");
	c_varb: cover property (ok && host_variant_o == 2'b01);
	c_read: cover property (read_i && !waitrequest_o);
	c_two: cover property (ok && memory_size_mb_o == 7'h02);
endmodule : strap_props
`default_nettype wire
